// >>> hdl/fpi_host.sv
// Programming host: runs JTAG enter/leave/erase sequences and serial write frames.
// Assumes one command at a time from logic on clk; target pins are asynchronous.
`timescale 1ns/1ps
// Function
// - Keep at least 11 TCK cycles between update-DR states in page load.
// - Enter: core-reset with one, then unlock instruction with 16-bit key.
// - Leave: command entry, no-operation, zero key, then zero into reset register.
// - Erase: command entry, start command, then poll with poll command.
// - Page write frame is 4C, address high, address low, 00.
// - EEPROM byte C0 with 10-bit address and data; page C2, low bits zero.
// - Configuration writes: AC, then E0/A0/A8/A4, then 00 and data.
// - Fuse and lock bits: zero programmed, one unprogrammed; unused left one.
// - Poll response bit zero one means busy; wait for zero before next.
// - Load low data byte before high data byte of each word.
module fpi_host
	import fpi_pkg::*;
(
	input wire logic clk,
	input wire logic rst,
	input wire logic cmd_valid,
	output logic cmd_ready,
	input wire fpi_op_e cmd_op,
	input wire logic [15:0] cmd_addr,
	input wire logic [15:0] cmd_data,
	input wire logic [1:0] cmd_cfg_sel,
	output logic done,
	output logic [7:0] rsp_data,
	output logic ser_rst_n,
	output logic tck,
	output logic tms,
	output logic tdi,
	input wire logic tdo,
	output logic sck,
	output logic mosi,
	input wire logic miso
);
	typedef enum logic [2:0] {
		S_IDLE = 3'h0, S_SSTEP = 3'h1, S_SWAIT = 3'h3, S_POLL = 3'h2,
		S_PWAIT = 3'h6, S_DONE = 3'h7, S_JSTEP = 3'h5, S_JWAIT = 3'h4
	} fpi_st_e;

	function automatic fpi_step_s ir_step(input logic [3:0] opc, input logic last);
		ir_step = '{last: last, ir: 1'b1, len: IR_LEN, val: {12'h000, opc}};
	endfunction : ir_step

	function automatic fpi_step_s dr_step(input logic [4:0] len, input logic [15:0] val,
		input logic last);
		dr_step = '{last: last, ir: 1'b0, len: len, val: val};
	endfunction : dr_step

	// JTAG sequence table; each scan ends back in run-test/idle
	function automatic fpi_step_s j_step(input fpi_op_e op, input logic [2:0] idx);
		j_step = dr_step(RST_LEN, 16'h0000, 1'b1);
		case (op)
			OP_ENTER:
				case (idx)
					3'h0: j_step = ir_step(IR_CORE_RESET, 1'b0);
					// Core held in reset from here on while the bit stays one
					3'h1: j_step = dr_step(RST_LEN, 16'h0001, 1'b0);
					3'h2: j_step = ir_step(IR_UNLOCK, 1'b0);
					default: j_step = dr_step(KEY_LEN, UNLOCK_KEY, 1'b1);
				endcase
			OP_LEAVE:
				case (idx)
					3'h0: j_step = ir_step(IR_CMD_ENTRY, 1'b0);
					3'h1: j_step = dr_step(CMD_LEN, CMD_NOP, 1'b0);
					3'h2: j_step = ir_step(IR_UNLOCK, 1'b0);
					3'h3: j_step = dr_step(KEY_LEN, LOCK_KEY, 1'b0);
					3'h4: j_step = ir_step(IR_CORE_RESET, 1'b0);
					default: j_step = dr_step(RST_LEN, 16'h0000, 1'b1);
				endcase
			OP_ERASE:
				case (idx)
					3'h0: j_step = ir_step(IR_CMD_ENTRY, 1'b0);
					3'h1: j_step = dr_step(CMD_LEN, CMD_ERASE_START, 1'b0);
					default: j_step = dr_step(CMD_LEN, CMD_ERASE_POLL, 1'b1);
				endcase
			default: j_step = dr_step(RST_LEN, 16'h0000, 1'b1);
		endcase
	endfunction : j_step

	fpi_st_e st_r, st_nxt;
	fpi_op_e op_r;
	logic [15:0] addr_r, data_r;
	logic [1:0] sel_r;
	logic [2:0] idx_r, idx_nxt;
	logic [7:0] cfg_b;
	logic [31:0] frame;
	logic tap_busy, tap_done, ser_busy, ser_done;
	logic [15:0] tap_dout;
	logic [7:0] ser_rsp;
	fpi_step_s stp;

	assign cmd_ready = (st_r == S_IDLE);
	assign done = (st_r == S_DONE);
	wire take = cmd_valid && cmd_ready;
	wire take_jtag = (cmd_op == OP_ENTER) || (cmd_op == OP_LEAVE) || (cmd_op == OP_ERASE);
	assign stp = j_step(op_r, idx_r);
	wire tap_go = (st_r == S_JSTEP) && !tap_busy;
	wire ser_go = ((st_r == S_SSTEP) || (st_r == S_POLL)) && !ser_busy;
	wire erase_busy = (op_r == OP_ERASE) && stp.last && tap_dout[CMD_POLL_BIT];
	assign cfg_b = (sel_r == 2'h0) ? CFG_LOCK : (sel_r == 2'h1) ? CFG_FUSE_LO :
		(sel_r == 2'h2) ? CFG_FUSE_HI : CFG_FUSE_EXT;
	// Word address passes through untouched; page order is the user's
	wire [31:0] f_page = {OPC_PAGE_WR, addr_r[15:8], addr_r[7:0], PAD_BYTE};
	wire [31:0] f_ee = {OPC_EE_WR, 6'h00, addr_r[9:8], addr_r[7:0], data_r[7:0]};
	wire [31:0] f_eep = {OPC_EE_PAGE, 6'h00, addr_r[9:8], addr_r[7:2], 2'h0, PAD_BYTE};
	// User gives a mask of bits to program; those go out as zero, the rest stay one
	wire [31:0] f_cfg = {OPC_CFG, cfg_b, PAD_BYTE, ~data_r[7:0]};
	wire [31:0] f_lo = {OPC_LOAD_LO, addr_r[15:8], addr_r[7:0], data_r[7:0]};
	wire [31:0] f_hi = {OPC_LOAD_HI, addr_r[15:8], addr_r[7:0], data_r[15:8]};
	wire [31:0] f_poll = {OPC_POLL, PAD_BYTE, PAD_BYTE, PAD_BYTE};
	assign frame = (st_r == S_POLL) ? f_poll :
		(op_r == OP_PAGE_WR) ? f_page :
		(op_r == OP_EE_BYTE) ? f_ee :
		(op_r == OP_EE_PAGE) ? f_eep :
		(op_r == OP_CFG) ? f_cfg :
		(idx_r == 3'h0) ? f_lo : f_hi;

	always_comb
	begin
		st_nxt = st_r;
		idx_nxt = idx_r;
		case (st_r)
			S_IDLE:
				if (take)
				begin
					idx_nxt = 3'h0;
					st_nxt = take_jtag ? S_JSTEP : S_SSTEP;
				end
			S_JSTEP:
				if (tap_go)
					st_nxt = S_JWAIT;
			S_JWAIT:
				if (tap_done)
				begin
					if (erase_busy)
						st_nxt = S_JSTEP;
					else if (stp.last)
						st_nxt = S_DONE;
					else
					begin
						idx_nxt = idx_r + 3'h1;
						st_nxt = S_JSTEP;
					end
				end
			S_SSTEP:
				if (ser_go)
					st_nxt = S_SWAIT;
			S_SWAIT:
				if (ser_done)
				begin
					if (op_r != OP_LOAD_WORD)
						st_nxt = S_POLL;
					else if (idx_r == 3'h0)
					begin
						// Low byte of the word is loaded first
						idx_nxt = 3'h1;
						st_nxt = S_SSTEP;
					end
					else
						st_nxt = S_DONE;
				end
			S_POLL:
				if (ser_go)
					st_nxt = S_PWAIT;
			S_PWAIT:
				if (ser_done)
					st_nxt = ser_rsp[0] ? S_POLL : S_DONE;
			S_DONE: st_nxt = S_IDLE;
			default: st_nxt = S_IDLE;
		endcase
	end

	always_ff @(posedge clk)
	begin
		if (rst)
		begin
			st_r <= S_IDLE; idx_r <= 3'h0; op_r <= OP_ENTER; addr_r <= 16'h0000;
			data_r <= 16'h0000; sel_r <= 2'h0;
		end
		else
		begin
			st_r <= st_nxt; idx_r <= idx_nxt;
			if (take)
			begin
				op_r <= cmd_op; addr_r <= cmd_addr; data_r <= cmd_data; sel_r <= cmd_cfg_sel;
			end
		end
	end

	// Target reset pin is held while a serial session is open; leave releases it
	always_ff @(posedge clk)
	begin
		if (rst)
		begin
			rsp_data <= 8'h00; ser_rst_n <= 1'b1;
		end
		else
		begin
			if (ser_done)
				rsp_data <= ser_rsp;
			else if (tap_done)
				rsp_data <= tap_dout[7:0];
			if (take)
				ser_rst_n <= take_jtag ? (cmd_op == OP_LEAVE) | ser_rst_n : 1'b0;
		end
	end

	fpi_tap_master u_tap (
		.clk(clk), .rst(rst), .go(tap_go), .is_ir(stp.ir), .len(stp.len), .din(stp.val),
		.busy(tap_busy), .done(tap_done), .dout(tap_dout),
		.tck(tck), .tms(tms), .tdi(tdi), .tdo(tdo)
	);

	fpi_ser_frame u_ser (
		.clk(clk), .rst(rst), .go(ser_go), .frame(frame), .busy(ser_busy),
		.done(ser_done), .rsp(ser_rsp), .sck(sck), .mosi(mosi), .miso(miso)
	);

	a_reset_instr: assert property (@(posedge clk) disable iff (rst)
		(tap_go && op_r == OP_ENTER && idx_r == 3'h0) |-> (stp.ir && stp.val[3:0] == 4'hC))
		else $error("enter does not start with core reset");
	a_unlock_key: assert property (@(posedge clk) disable iff (rst)
		(tap_go && op_r == OP_ENTER && stp.last) |-> (!stp.ir && stp.val == 16'hA370 &&
		stp.len == 5'h10))
		else $error("unlock key wrong");
	a_leave_release: assert property (@(posedge clk) disable iff (rst)
		(tap_go && op_r == OP_LEAVE && stp.last) |-> (idx_r == 3'h5 && stp.val == 16'h0000 &&
		stp.len == 5'h01))
		else $error("leave does not end with reset release");
	a_erase_poll: assert property (@(posedge clk) disable iff (rst)
		(st_r == S_JWAIT && tap_done && erase_busy) |=> (st_r == S_JSTEP && idx_r == 3'h2))
		else $error("erase poll not repeated");
	a_page_frame: assert property (@(posedge clk) disable iff (rst)
		(ser_go && st_r == S_SSTEP && op_r == OP_PAGE_WR) |->
		(frame[31:24] == 8'h4C && frame[7:0] == 8'h00 && frame[23:8] == addr_r))
		else $error("page write frame malformed");
	a_ee_page: assert property (@(posedge clk) disable iff (rst)
		(ser_go && st_r == S_SSTEP && op_r == OP_EE_PAGE) |->
		(frame[31:24] == 8'hC2 && frame[23:18] == 6'h00 && frame[9:0] == 10'h000))
		else $error("eeprom page frame malformed");
	a_cfg_frame: assert property (@(posedge clk) disable iff (rst)
		(ser_go && st_r == S_SSTEP && op_r == OP_CFG) |->
		(frame[31:24] == 8'hAC && frame[15:8] == 8'h00 && frame[7:0] == ~data_r[7:0]))
		else $error("configuration frame malformed");
	a_poll_wait: assert property (@(posedge clk) disable iff (rst)
		(st_r == S_PWAIT && ser_done && ser_rsp[0]) |=> (st_r == S_POLL) ##[1:2] (st_r == S_PWAIT))
		else $error("busy poll answer not honoured");
	a_low_first: assert property (@(posedge clk) disable iff (rst)
		(st_r == S_SWAIT && ser_done && op_r == OP_LOAD_WORD && idx_r == 3'h0) |=>
		(ser_go && frame[31:24] == OPC_LOAD_HI && frame[7:0] == data_r[15:8]))
		else $error("high byte not loaded after low byte");
endmodule : fpi_host

// >>> hdl/fpi_pkg.sv
// Constants, types and frame codes for the flash programming host.
// Assumes one 125 MHz clock; TCK and SCK are divided down from it.
package fpi_pkg;
	localparam int unsigned CLK_PERIOD_NS = 8;
	// TCK and SCK half periods in clk cycles
	localparam logic [3:0] TCK_HALF = 4'h4;
	localparam logic [3:0] TCK_LAST = 4'h7;
	localparam logic [3:0] SCK_HALF = 4'h8;
	localparam logic [3:0] SCK_LAST = 4'hF;
	localparam logic [4:0] TAP_RESET_CLKS = 5'h05;
	localparam logic [4:0] IR_LEN = 5'h04;
	localparam logic [4:0] RST_LEN = 5'h01;
	localparam logic [4:0] KEY_LEN = 5'h10;
	localparam logic [4:0] CMD_LEN = 5'h0F;
	localparam logic [4:0] MIN_UPD_GAP = 5'h0B;
	localparam logic [4:0] DR_OVERHEAD = 5'h05;
	localparam logic [5:0] FRAME_BITS = 6'h20;
	localparam logic [3:0] IR_CORE_RESET = 4'hC;
	// Opcodes and command words below are not fixed here; set them to the target
	localparam logic [3:0] IR_UNLOCK = 4'h4;
	localparam logic [3:0] IR_CMD_ENTRY = 4'h5;
	localparam logic [15:0] CMD_ERASE_START = 16'h0001;
	localparam logic [15:0] CMD_ERASE_POLL = 16'h0002;
	localparam logic [15:0] CMD_NOP = 16'h0003;
	localparam int unsigned CMD_POLL_BIT = 0;
	localparam logic [15:0] UNLOCK_KEY = 16'hA370;
	localparam logic [15:0] LOCK_KEY = 16'h0000;
	localparam logic [7:0] OPC_PAGE_WR = 8'h4C;
	localparam logic [7:0] OPC_EE_WR = 8'hC0;
	localparam logic [7:0] OPC_EE_PAGE = 8'hC2;
	localparam logic [7:0] OPC_CFG = 8'hAC;
	localparam logic [7:0] CFG_LOCK = 8'hE0;
	localparam logic [7:0] CFG_FUSE_LO = 8'hA0;
	localparam logic [7:0] CFG_FUSE_HI = 8'hA8;
	localparam logic [7:0] CFG_FUSE_EXT = 8'hA4;
	localparam logic [7:0] OPC_LOAD_LO = 8'h10;
	localparam logic [7:0] OPC_LOAD_HI = 8'h18;
	localparam logic [7:0] OPC_POLL = 8'h20;
	localparam logic [7:0] PAD_BYTE = 8'h00;

	typedef enum logic [2:0] {
		OP_ENTER = 3'h0,
		OP_LEAVE = 3'h1,
		OP_ERASE = 3'h2,
		OP_PAGE_WR = 3'h3,
		OP_EE_BYTE = 3'h4,
		OP_EE_PAGE = 3'h5,
		OP_CFG = 3'h6,
		OP_LOAD_WORD = 3'h7
	} fpi_op_e;

	typedef struct packed {
		logic last;
		logic ir;
		logic [4:0] len;
		logic [15:0] val;
	} fpi_step_s;
endpackage : fpi_pkg

// >>> hdl/fpi_tap_master.sv
// JTAG master: makes TCK from clk and runs one IR or DR scan from run-test/idle.
// Assumes tdo is asynchronous to clk; data is shifted LSB first.
`timescale 1ns/1ps
module fpi_tap_master
	import fpi_pkg::*;
(
	input wire logic clk,
	input wire logic rst,
	input wire logic go,
	input wire logic is_ir,
	input wire logic [4:0] len,
	input wire logic [15:0] din,
	output logic busy,
	output logic done,
	output logic [15:0] dout,
	output logic tck,
	output logic tms,
	output logic tdi,
	input wire logic tdo
);
	typedef enum logic [2:0] {
		T_RST = 3'h0, T_IDLE = 3'h1, T_HEAD = 3'h3, T_SHIFT = 3'h2,
		T_EXIT = 3'h6, T_UPD = 3'h7, T_WAIT = 3'h5
	} fpi_tap_e;

	fpi_tap_e st_r;
	logic [3:0] ph_r;
	logic [4:0] cnt_r, len_r, gap_r;
	logic [15:0] sh_r, cap_r;
	logic req_r, ir_r, shcyc_r, tdo_m_r, tdo_s_r;
	wire [3:0] ph_nxt = (ph_r == TCK_LAST) ? 4'h0 : ph_r + 4'h1;
	wire lo = (ph_r == 4'h0);
	wire smp = (ph_r == TCK_LAST);
	wire [4:0] used = len_r + DR_OVERHEAD;
	// Short DR scans idle in run-test/idle to keep update-DR spacing
	wire [4:0] pad = (used < MIN_UPD_GAP) ? MIN_UPD_GAP - used : 5'h00;
	wire fin = lo && ((st_r == T_UPD && pad == 5'h00) || (st_r == T_WAIT && cnt_r == 5'h01));

	assign busy = req_r | (st_r != T_IDLE);

	always_ff @(posedge clk)
	begin
		tdo_m_r <= tdo;
		tdo_s_r <= tdo_m_r;
		if (smp && shcyc_r)
			cap_r <= {tdo_s_r, cap_r[15:1]};
	end

	always_ff @(posedge clk)
	begin
		if (rst)
		begin
			st_r <= T_RST; ph_r <= 4'h0; cnt_r <= 5'h00; req_r <= 1'b0; ir_r <= 1'b0;
			len_r <= 5'h00; sh_r <= 16'h0000; shcyc_r <= 1'b0; tck <= 1'b0;
			tms <= 1'b1; tdi <= 1'b0; done <= 1'b0; dout <= 16'h0000;
		end
		else
		begin
			ph_r <= ph_nxt;
			tck <= (ph_nxt >= TCK_HALF);
			done <= fin;
			if (go && !busy)
			begin
				req_r <= 1'b1; ir_r <= is_ir; len_r <= len; sh_r <= din;
			end
			if (fin)
			begin
				st_r <= T_IDLE; req_r <= 1'b0; dout <= cap_r >> (5'h10 - len_r);
			end
			if (lo)
			begin
				case (st_r)
					T_RST:
					begin
						// Five TMS-high clocks, then one low so the target settles in run-test/idle
						tms <= (cnt_r != TAP_RESET_CLKS); cnt_r <= cnt_r + 5'h01;
						if (cnt_r == TAP_RESET_CLKS)
							st_r <= T_IDLE;
					end
					T_IDLE:
					begin
						// Parked in run-test/idle between scans
						tms <= req_r;
						shcyc_r <= 1'b0;
						if (req_r)
						begin
							st_r <= T_HEAD; cnt_r <= ir_r ? 5'h03 : 5'h02;
						end
					end
					T_HEAD:
					begin
						tms <= ir_r && (cnt_r == 5'h03);
						cnt_r <= (cnt_r == 5'h01) ? len_r : cnt_r - 5'h01;
						if (cnt_r == 5'h01)
							st_r <= T_SHIFT;
					end
					T_SHIFT:
					begin
						tms <= (cnt_r == 5'h01); tdi <= sh_r[0];
						sh_r <= {1'b0, sh_r[15:1]}; shcyc_r <= 1'b1; cnt_r <= cnt_r - 5'h01;
						if (cnt_r == 5'h01)
							st_r <= T_EXIT;
					end
					T_EXIT:
					begin
						tms <= 1'b1; shcyc_r <= 1'b0; st_r <= T_UPD;
					end
					T_UPD:
					begin
						tms <= 1'b0; cnt_r <= pad;
						if (pad != 5'h00)
							st_r <= T_WAIT;
					end
					T_WAIT:
					begin
						tms <= 1'b0; cnt_r <= cnt_r - 5'h01;
					end
					default: st_r <= T_RST;
				endcase
			end
		end
	end

	// Edges since the last update-DR, only watched by an assertion
	always_ff @(posedge clk)
	begin
		if (rst)
			gap_r <= 5'h1F;
		else if (lo && st_r == T_EXIT && !ir_r)
			gap_r <= 5'h00;
		else if (lo && gap_r != 5'h1F)
			gap_r <= gap_r + 5'h01;
	end

	a_update_gap: assert property (@(posedge clk) disable iff (rst)
		(lo && st_r == T_EXIT && !ir_r) |-> (gap_r >= 5'h0A))
		else $error("update-DR spacing below minimum");
	a_ir_width: assert property (@(posedge clk) disable iff (rst)
		(lo && st_r == T_HEAD && ir_r && cnt_r == 5'h01) |-> (len_r == IR_LEN))
		else $error("instruction scan not four bits");
endmodule : fpi_tap_master

// >>> hdl/fpi_ser_frame.sv
// Serial programming shifter: one 32-bit frame, MSB first, SCK idles low.
// Assumes miso is asynchronous; response is the last byte shifted in.
`timescale 1ns/1ps
module fpi_ser_frame
	import fpi_pkg::*;
(
	input wire logic clk,
	input wire logic rst,
	input wire logic go,
	input wire logic [31:0] frame,
	output logic busy,
	output logic done,
	output logic [7:0] rsp,
	output logic sck,
	output logic mosi,
	input wire logic miso
);
	logic run_r, miso_m_r, miso_s_r;
	logic [3:0] ph_r;
	logic [5:0] cnt_r, bits_r;
	logic [31:0] sh_r, rx_r;
	wire [3:0] ph_nxt = (ph_r == SCK_LAST) ? 4'h0 : ph_r + 4'h1;
	wire bit_end = run_r && (ph_r == SCK_LAST);

	assign busy = run_r;

	always_ff @(posedge clk)
	begin
		miso_m_r <= miso;
		miso_s_r <= miso_m_r;
	end

	always_ff @(posedge clk)
	begin
		if (rst)
		begin
			run_r <= 1'b0; ph_r <= 4'h0; cnt_r <= 6'h00; sh_r <= 32'h00000000;
			rx_r <= 32'h00000000; sck <= 1'b0; mosi <= 1'b0; done <= 1'b0; rsp <= 8'h00;
		end
		else
		begin
			done <= bit_end && (cnt_r == 6'h01);
			sck <= run_r && (ph_nxt >= SCK_HALF) && !(bit_end && cnt_r == 6'h01);
			if (go && !run_r)
			begin
				run_r <= 1'b1; ph_r <= 4'h0; cnt_r <= FRAME_BITS; sh_r <= frame;
			end
			else if (run_r)
			begin
				ph_r <= ph_nxt;
				if (ph_r == 4'h0)
					mosi <= sh_r[31];
				if (bit_end)
				begin
					// Four bytes back to back, MSB first
					rx_r <= {rx_r[30:0], miso_s_r};
					sh_r <= {sh_r[30:0], 1'b0};
					cnt_r <= cnt_r - 6'h01;
					if (cnt_r == 6'h01)
					begin
						run_r <= 1'b0; rsp <= {rx_r[6:0], miso_s_r};
					end
				end
			end
		end
	end

	always_ff @(posedge clk)
	begin
		if (rst || (go && !run_r))
			bits_r <= 6'h00;
		else if (run_r && ph_r == SCK_HALF)
			bits_r <= bits_r + 6'h01;
	end

	a_frame_bits: assert property (@(posedge clk) disable iff (rst)
		done |-> (bits_r == FRAME_BITS))
		else $error("frame did not carry 32 clocks");
endmodule : fpi_ser_frame

// >>> test/fpi_target_model.sv
// Behavioural target: JTAG TAP with reset, unlock and command registers, plus a serial slave.
// Assumes tck and sck come from the host; the model has no clock of its own.
`timescale 1ns/1ps
module fpi_target_model
	import fpi_pkg::*;
(
	input wire logic tck,
	input wire logic tms,
	input wire logic tdi,
	output logic tdo,
	input wire logic sck,
	input wire logic mosi,
	output logic miso,
	input wire logic ser_rst_n,
	input wire logic [3:0] jbusy_cfg,
	input wire logic [3:0] sbusy_cfg,
	output logic core_rst,
	output logic prog_mode,
	output logic [3:0] ir_q,
	output logic gap_err,
	output logic erase_seen,
	output logic nop_seen,
	output logic [7:0] n_jpolls,
	output logic [7:0] n_polls,
	output logic [31:0] last_frame,
	output logic [31:0] prev_frame,
	output logic in_idle
);
	logic [3:0] st = 4'h0;
	logic [3:0] nx;
	logic [15:0] sr = 16'h0000;
	logic [4:0] dlen;
	logic [3:0] jbusy = 4'h0;
	logic [3:0] sbusy = 4'h0;
	logic [4:0] gap = 5'h00;
	logic [31:0] sh = 32'h00000000;
	logic [4:0] bits = 5'h00;
	logic [31:0] f_w;
	logic [7:0] srsp = 8'h00;

	initial
	begin
		{tdo, miso, core_rst, prog_mode, gap_err, erase_seen, nop_seen} = 7'h00;
		ir_q = 4'hF;
		{n_jpolls, n_polls} = 16'h0000;
		{last_frame, prev_frame} = 64'h0;
	end

	// States: 0 reset, 1 idle, 2-8 DR path, 9-15 IR path
	always_comb
	begin
		case (st)
			4'h0: nx = tms ? 4'h0 : 4'h1;
			4'h1, 4'h8, 4'hF: nx = tms ? 4'h2 : 4'h1;
			4'h2: nx = tms ? 4'h9 : 4'h3;
			4'h3, 4'h4: nx = tms ? 4'h5 : 4'h4;
			4'h5: nx = tms ? 4'h8 : 4'h6;
			4'h6: nx = tms ? 4'h7 : 4'h6;
			4'h7: nx = tms ? 4'h8 : 4'h4;
			4'h9: nx = tms ? 4'h0 : 4'hA;
			4'hA, 4'hB: nx = tms ? 4'hC : 4'hB;
			4'hC: nx = tms ? 4'hF : 4'hD;
			4'hD: nx = tms ? 4'hE : 4'hD;
			default: nx = tms ? 4'hF : 4'hB;
		endcase
	end
	assign in_idle = (st == 4'h1);
	assign dlen = (ir_q == IR_CORE_RESET) ? RST_LEN : (ir_q == IR_UNLOCK) ? KEY_LEN :
		(ir_q == IR_CMD_ENTRY) ? CMD_LEN : 5'h01;

	always @(posedge tck)
	begin
		case (st)
			4'h0: ir_q <= 4'hF;
			4'h3: sr <= (ir_q == IR_CMD_ENTRY) ? (16'(jbusy != 4'h0) << CMD_POLL_BIT)
				: {15'h0000, core_rst};
			4'h4:
			begin
				sr <= (sr >> 1) | ({15'h0000, tdi} << (dlen - 5'h01));
				if (ir_q == IR_CORE_RESET)
					core_rst <= tdi;
			end
			4'hA: sr <= 16'h0001;
			4'hB: sr <= (sr >> 1) | ({15'h0000, tdi} << (IR_LEN - 5'h01));
			4'hF: ir_q <= sr[3:0];
			4'h8:
			begin
				if (ir_q == IR_UNLOCK && sr == UNLOCK_KEY && core_rst)
					prog_mode <= 1'b1;
				if (ir_q == IR_UNLOCK && sr == LOCK_KEY)
					prog_mode <= 1'b0;
				if (ir_q == IR_CMD_ENTRY && sr[14:0] == CMD_NOP[14:0])
					nop_seen <= 1'b1;
				if (ir_q == IR_CMD_ENTRY && sr[14:0] == CMD_ERASE_START[14:0])
				begin
					erase_seen <= 1'b1;
					jbusy <= jbusy_cfg;
				end
				if (ir_q == IR_CMD_ENTRY && sr[14:0] == CMD_ERASE_POLL[14:0])
				begin
					n_jpolls <= n_jpolls + 8'h01;
					if (jbusy != 4'h0)
						jbusy <= jbusy - 4'h1;
				end
			end
			default: ;
		endcase
		// Page load needs enough TCKs between updates for the byte engine
		gap <= (nx == 4'h8) ? 5'h00 : ((gap == 5'h1F) ? gap : gap + 5'h01);
		if (nx == 4'h8 && gap < 5'h0A)
			gap_err <= 1'b1;
		st <= nx;
	end

	always @(negedge tck)
		tdo <= (st == 4'h4 || st == 4'hB) ? sr[0] : ~tdo;

	// Any word address is accepted; busy polls stand in for the self-timed write
	assign f_w = {sh[30:0], mosi};
	always @(posedge sck)
	begin
		if (!ser_rst_n)
		begin
			sh <= f_w;
			bits <= bits + 5'h01;
			// Reply is fixed once three bytes are in; later shifts must not alter it
			if (bits == 5'h17)
				srsp <= (f_w[23:16] == OPC_POLL) ? {7'h00, sbusy != 4'h0} : 8'h00;
			if (bits == 5'h1F && f_w[31:24] == OPC_POLL)
			begin
				n_polls <= n_polls + 8'h01;
				if (sbusy != 4'h0)
					sbusy <= sbusy - 4'h1;
			end
			else if (bits == 5'h1F)
			begin
				prev_frame <= last_frame;
				last_frame <= f_w;
				if (f_w[31:24] != OPC_LOAD_LO && f_w[31:24] != OPC_LOAD_HI)
					sbusy <= sbusy_cfg;
			end
		end
	end
	// Outside the reply byte the line carries no data, so it keeps changing
	always @(negedge sck)
		miso <= (bits >= 5'h18) ? srsp[5'h1F - bits] : ~miso;
endmodule : fpi_target_model

// >>> test/fpi_host_tb_top.sv
// Self-checking bench for the programming host against the behavioural target.
// Assumes the host alone makes tck and sck.
`timescale 1ns/1ps
`define CHK(nm, exp, got) \
	begin \
		n_checks++; \
		if ((got) !== (exp)) \
		begin \
			bad_count++; \
			$display("Error %s expected %h seen %h", nm, exp, got); \
		end \
	end
module fpi_host_tb_top;
	import fpi_pkg::*;
	logic clk, rst, cmd_valid, cmd_ready, done, ser_rst_n;
	logic tck, tms, tdi, tdo, sck, mosi, miso;
	fpi_op_e cmd_op;
	logic [15:0] cmd_addr, cmd_data;
	logic [1:0] cmd_cfg_sel;
	logic [7:0] rsp_data, n_jpolls, n_polls;
	logic [3:0] jbusy_cfg, sbusy_cfg, ir_q;
	logic core_rst, prog_mode, gap_err, erase_seen, nop_seen, in_idle;
	logic [31:0] last_frame, prev_frame;
	int bad_count = 0;
	int n_checks = 0;
	int cyc = 0;

	fpi_host fpi_host_i (.clk(clk), .rst(rst), .cmd_valid(cmd_valid), .cmd_ready(cmd_ready),
		.cmd_op(cmd_op), .cmd_addr(cmd_addr), .cmd_data(cmd_data), .cmd_cfg_sel(cmd_cfg_sel),
		.done(done), .rsp_data(rsp_data), .ser_rst_n(ser_rst_n), .tck(tck), .tms(tms),
		.tdi(tdi), .tdo(tdo), .sck(sck), .mosi(mosi), .miso(miso));
	fpi_target_model fpi_target_model_i (.tck(tck), .tms(tms), .tdi(tdi), .tdo(tdo), .sck(sck),
		.mosi(mosi), .miso(miso), .ser_rst_n(ser_rst_n), .jbusy_cfg(jbusy_cfg),
		.sbusy_cfg(sbusy_cfg), .core_rst(core_rst), .prog_mode(prog_mode), .ir_q(ir_q),
		.gap_err(gap_err), .erase_seen(erase_seen), .nop_seen(nop_seen), .n_jpolls(n_jpolls),
		.n_polls(n_polls), .last_frame(last_frame), .prev_frame(prev_frame), .in_idle(in_idle));

	initial
	begin
		clk = 1'b0;
		forever #4 clk = ~clk;
	end

	task automatic print_verdict();
		$display("checks %0d mismatches %0d", n_checks, bad_count);
		if (bad_count == 0 && n_checks > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask : print_verdict

	// Slow scans make this generous; a hung poll loop lands here
	always @(posedge clk)
	begin
		cyc++;
		if (cyc == 90000)
		begin
			bad_count++;
			print_verdict();
		end
	end

	task automatic do_cmd(input fpi_op_e op, input logic [15:0] a, input logic [15:0] d,
		input logic [1:0] s);
		int n;
		@(posedge clk);
		cmd_valid <= 1'b1;
		cmd_op <= op;
		cmd_addr <= a;
		cmd_data <= d;
		cmd_cfg_sel <= s;
		n = 0;
		do
		begin
			@(posedge clk);
			n++;
		end
		while (cmd_ready !== 1'b1 && n < 2000);
		cmd_valid <= 1'b0;
		n = 0;
		do
		begin
			@(posedge clk);
			n++;
		end
		while (done !== 1'b1 && n < 20000);
		`CHK("done", 1'b1, done)
		// Done can lead the final link clock edge; let it land before the target is read
		repeat (8) @(posedge clk);
	endtask : do_cmd

	task automatic t_enter();
		do_cmd(OP_ENTER, 16'h0000, 16'h0000, 2'h0);
		`CHK("core_rst", 1'b1, core_rst)
		`CHK("prog_mode", 1'b1, prog_mode)
		`CHK("ir", IR_UNLOCK, ir_q)
		`CHK("idle", 1'b1, in_idle)
		$display("test enter done");
	endtask : t_enter

	task automatic t_erase();
		jbusy_cfg <= 4'h2;
		do_cmd(OP_ERASE, 16'h0000, 16'h0000, 2'h0);
		`CHK("erase", 1'b1, erase_seen)
		`CHK("jpolls", 8'h03, n_jpolls)
		`CHK("ir", IR_CMD_ENTRY, ir_q)
		`CHK("gap", 1'b0, gap_err)
		`CHK("jtag reply", 8'h00, rsp_data)
		$display("test erase done");
	endtask : t_erase

	task automatic ser_case(input fpi_op_e op, input logic [15:0] a, input logic [15:0] d,
		input logic [1:0] s, input logic [31:0] f, input logic [3:0] nb);
		logic [7:0] p0;
		p0 = n_polls;
		sbusy_cfg <= nb;
		do_cmd(op, a, d, s);
		`CHK("frame", f, last_frame)
		`CHK("polls", p0 + {4'h0, nb} + 8'h01, n_polls)
		`CHK("reply", 8'h00, rsp_data)
		$display("test serial op %0d done", op);
	endtask : ser_case

	task automatic t_load();
		logic [7:0] p0;
		p0 = n_polls;
		do_cmd(OP_LOAD_WORD, 16'h0005, 16'hBEEF, 2'h0);
		`CHK("first opcode", OPC_LOAD_LO, prev_frame[31:24])
		`CHK("first data", 8'hEF, prev_frame[7:0])
		`CHK("second opcode", OPC_LOAD_HI, last_frame[31:24])
		`CHK("second data", 8'hBE, last_frame[7:0])
		`CHK("polls", p0, n_polls)
		$display("test load done");
	endtask : t_load

	task automatic t_leave();
		do_cmd(OP_LEAVE, 16'h0000, 16'h0000, 2'h0);
		`CHK("nop", 1'b1, nop_seen)
		`CHK("prog_mode", 1'b0, prog_mode)
		`CHK("core_rst", 1'b0, core_rst)
		`CHK("ir", IR_CORE_RESET, ir_q)
		`CHK("ser_rst_n", 1'b1, ser_rst_n)
		`CHK("gap", 1'b0, gap_err)
		$display("test leave done");
	endtask : t_leave

	initial
	begin
		logic [7:0] codes [4];
		codes = '{CFG_LOCK, CFG_FUSE_LO, CFG_FUSE_HI, CFG_FUSE_EXT};
		rst = 1'b1;
		cmd_valid = 1'b0;
		cmd_op = OP_ENTER;
		{cmd_addr, cmd_data, cmd_cfg_sel} = 34'h0;
		jbusy_cfg = 4'h0;
		sbusy_cfg = 4'h0;
		repeat (6) @(posedge clk);
		rst <= 1'b0;
		t_enter();
		t_erase();
		ser_case(OP_PAGE_WR, 16'h1234, 16'h0000, 2'h0, 32'h4C123400, 4'h2);
		ser_case(OP_EE_BYTE, 16'h03FF, 16'h00A5, 2'h0, 32'hC003FFA5, 4'h0);
		ser_case(OP_EE_PAGE, 16'h0107, 16'h0000, 2'h0, 32'hC2010400, 4'h1);
		for (int i = 0; i < 4; i++)
			ser_case(OP_CFG, 16'h0000, 16'h0081, 2'(i), {OPC_CFG, codes[i], 16'h007E},
				4'h0);
		t_load();
		t_leave();
		print_verdict();
	end
endmodule : fpi_host_tb_top
